// ### anps_engine_model.sv
/*
  Negotiation engine model: one-cycle page strobes with fields, link levels.
  Assumes the bench calls its tasks; outputs move just after a rising edge.
*/
`timescale 1ns/1ps
module anps_engine_model (
  input  wire logic        pclk,
  output logic             page_strobe,
  output logic             rx_message_page,
  output logic             rx_partner_can_comply,
  output logic             rx_toggle,
  output logic      [10:0] rx_code,
  output logic             parallel_detect_fault,
  output logic             partner_multi_page_capable,
  output logic             partner_negotiation_capable
);
  // Quiet engine at time zero
  initial begin
    {page_strobe, rx_message_page, rx_partner_can_comply, rx_toggle, rx_code} = '0;
    {parallel_detect_fault, partner_multi_page_capable, partner_negotiation_capable} = '0;
  end
  // Fields inverted after the strobe, so late sampling shows up
  task automatic send_page(input logic msg, comply, tog, input logic [10:0] code);
    @(posedge pclk);
    page_strobe <= 1'b1;
    {rx_message_page, rx_partner_can_comply, rx_toggle, rx_code} <= {msg, comply, tog, code};
    @(posedge pclk);
    page_strobe <= 1'b0;
    {rx_message_page, rx_partner_can_comply, rx_toggle, rx_code} <= ~{msg, comply, tog, code};
  endtask : send_page
  // Levels take one cycle inside, so allow two
  task automatic set_levels(input logic [2:0] lv);
    @(posedge pclk);
    {parallel_detect_fault, partner_multi_page_capable, partner_negotiation_capable} <= lv;
    repeat (2) @(posedge pclk);
  endtask : set_levels
endmodule : anps_engine_model

// ### anps_pkg.sv
/*
  Package for the auto-negotiation partner page status block: register
  offsets, field positions and reset values.
  Assumes an APB slave with 32-bit data and word-aligned registers.
*/
package anps_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]  EXP_IDX      = 8'h06;  // Expansion status index
  localparam logic [7:0]  NPA_IDX      = 8'h08;  // Next-page view index
  localparam logic [11:0] EXP_ADDR     = 12'h018; // Expansion byte address
  localparam logic [11:0] NPA_ADDR     = 12'h020; // Next-page view byte address
  // Next-page view fields
  localparam int NPA_MSG_BIT    = 13;  // Message page flag
  localparam int NPA_COMPLY_BIT = 12;  // Partner can comply
  localparam int NPA_TOG_BIT    = 11;  // Toggle
  localparam int CODE_W         = 11;  // Code field width
  // Expansion fields
  localparam int EXP_FAULT_BIT  = 4;   // Parallel detect fault
  localparam int EXP_LPNP_BIT   = 3;   // Partner multi-page capable
  localparam int EXP_LNP_BIT    = 2;   // Local multi-page capable
  localparam int EXP_PRX_BIT    = 1;   // Page received
  localparam int EXP_LPAN_BIT   = 0;   // Partner negotiation capable
  // Reset values
  localparam logic [CODE_W-1:0] CODE_RST = 11'h000; // Code field reset
  localparam logic              LNP_VAL  = 1'b1;    // Permanent local ability
  localparam logic [31:0]       ZERO32   = 32'h0000_0000; // Idle read data
endpackage : anps_pkg

// ### anps_pulse_set.sv
/*
  Sticky flag with a set that wins over a clear.
  Assumes set and clear are single-cycle and synchronous to pclk.
*/
`timescale 1ns/1ps
module anps_pulse_set (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);
  // Set over clear so an event during the clearing read is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end

  AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    set_i |=> flag_o)
    else $error("page flag lost its set");
endmodule : anps_pulse_set

// ### anps_status.sv
/*
  Auto-negotiation partner page status: next-page view of the partner and
  the expansion register, read over APB.
  Assumes the negotiation engine presents decoded page fields with a
  one-cycle page strobe, synchronous to pclk.

  Register map, byte addresses on paddr:
    0x018  expansion status, 16 bits in the low half of the word
    0x020  partner next-page view, 16 bits in the low half of the word
  Any other address answers with pslverr and zero data.

  Next-page view layout:
    13     message page flag of the last received page
    12     partner can comply with the message
    11     inverse of the toggle of the previous link code word
    10:0   code field of the last received page
    15:14  not held here; they read zero

  Expansion layout:
    15:5   reserved, zero, writes ignored
    4      parallel detection fault, follows the engine
    3      partner multi-page capable, follows the engine
    2      local multi-page capable, fixed at one
    1      page received, sticky, cleared by a read of this register
    0      partner negotiation capable, follows the engine

  Timing: no wait state on any transfer. The read answer is taken at
  the setup edge, so the page flag reported is the one seen before the
  clear; a page arriving on that same edge survives for the next read.
  Limitation: the engine must hold its levels stable for a cycle before
  software expects them; there is no synchroniser on these inputs.
  All registers are read-only; pwdata is never looked at.
*/
//
// What this block does
// - Bit 12 reports partner can comply
// - Bit 11 reports inverted previous toggle
// - Bits 10:0 hold received code field
// - Expansion bits 15:5 read zero, ignore writes
// - Bit 4 reports parallel detection fault
// - Bit 3 reports partner next page ability
// - Bit 2 reads permanent one
// - Bit 1 page received, cleared on read
// - Bit 0 reports partner auto-negotiation ability
`timescale 1ns/1ps
module anps_status (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        page_strobe,
  input  wire logic        rx_message_page,
  input  wire logic        rx_partner_can_comply,
  input  wire logic        rx_toggle,
  input  wire logic [10:0] rx_code,
  input  wire logic        parallel_detect_fault,
  input  wire logic        partner_multi_page_capable,
  input  wire logic        partner_negotiation_capable
);
  localparam int CW = anps_pkg::CODE_W;

  logic          message_page_flag_r;   // Message page flag
  logic          partner_can_comply_r;  // Partner comply flag
  logic          toggle_r;              // Inverted toggle
  logic [CW-1:0] code_r;                // Received code
  logic          fault_r;               // Parallel detect fault
  logic          lpnp_r;                // Partner next-page able
  logic          lpan_r;                // Partner autoneg able
  logic          page_rx;               // Sticky page received
  logic          setup_ph;              // APB setup cycle
  logic          rd_exp;                // Setup of an expansion read
  logic          sel_exp;               // Address hits expansion
  logic          sel_npa;               // Address hits next-page view
  logic [15:0]   exp_view;              // Expansion read view
  logic [15:0]   npa_view;              // Next-page read view
  logic          pready_nxt;            // Answer due next cycle
  // Check helpers; they feed only the assertions and covers below
  logic          acc_ph;                // APB access cycle
  logic          rd_npa;                // Setup of a next-page read
  logic          rd_done;               // Read completes this cycle
  logic          wr_setup;              // Setup of a write

  // Address decode: full compare of the byte address, so aliases of the
  // two registers answer as unmapped rather than as silent copies
  assign sel_exp  = (paddr == anps_pkg::EXP_ADDR);
  assign sel_npa  = (paddr == anps_pkg::NPA_ADDR);
  assign setup_ph = psel && !penable;
  // Clear on the setup of a read; the answer is captured that same edge
  assign rd_exp   = setup_ph && !pwrite && sel_exp;
  assign pready_nxt = setup_ph;
  // Helpers for the checks
  assign acc_ph   = psel && penable;
  assign rd_npa   = setup_ph && !pwrite && sel_npa;
  assign rd_done  = acc_ph && pready && !pwrite;
  assign wr_setup = setup_ph && pwrite;

  // Page fields latch on each received page. They are held until the
  // next strobe, so software sees the whole last page, never a mix of
  // two; a read does not disturb them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      message_page_flag_r  <= 1'b0;
      partner_can_comply_r <= 1'b0;
      toggle_r             <= 1'b0;
      code_r               <= anps_pkg::CODE_RST;
    end else if (page_strobe) begin
      message_page_flag_r  <= rx_message_page;
      partner_can_comply_r <= rx_partner_can_comply;
      toggle_r             <= ~rx_toggle;
      code_r               <= rx_code;
    end
  end

  // Partner and fault status follow the engine every cycle. One flop of
  // delay keeps the read path free of the engine's combinational outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r <= 1'b0;
      lpnp_r  <= 1'b0;
      lpan_r  <= 1'b0;
    end else begin
      fault_r <= parallel_detect_fault;
      lpnp_r  <= partner_multi_page_capable;
      lpan_r  <= partner_negotiation_capable;
    end
  end

  // Sticky page-received flag. Only a read of the expansion register
  // clears it; writes and next-page reads leave it alone, and a page on
  // the clearing edge wins so no arrival goes unseen.
  anps_pulse_set u_page_flag (
    .pclk    (pclk),
    .presetn (presetn),
    .set_i   (page_strobe),
    .clr_i   (rd_exp),
    .flag_o  (page_rx)
  );

  // Read views; reserved upper bits are constant zero. Both start from
  // zero so any bit not named below reads zero and never floats.
  always_comb begin
    exp_view = 16'h0000;
    // Expansion fields
    exp_view[anps_pkg::EXP_FAULT_BIT] = fault_r;
    exp_view[anps_pkg::EXP_LPNP_BIT]  = lpnp_r;
    exp_view[anps_pkg::EXP_LNP_BIT]   = anps_pkg::LNP_VAL;
    exp_view[anps_pkg::EXP_PRX_BIT]   = page_rx;
    exp_view[anps_pkg::EXP_LPAN_BIT]  = lpan_r;
    // Next-page view fields; bits 15:14 are not held here
    npa_view = 16'h0000;
    npa_view[anps_pkg::NPA_MSG_BIT]    = message_page_flag_r;
    npa_view[anps_pkg::NPA_COMPLY_BIT] = partner_can_comply_r;
    npa_view[anps_pkg::NPA_TOG_BIT]  = toggle_r;
    npa_view[CW-1:0]                 = code_r;
  end

  // APB answer: no wait state, data registered at setup.
  // Writes are accepted and dropped; every register is read-only.
  // Read data is taken at the setup edge, the same edge that clears the
  // page flag, so the answer shows the flag as it stood before the clear.
  // prdata then holds until the next setup; it is not zeroed after use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= anps_pkg::ZERO32;
    end else begin
      pready  <= pready_nxt;
      pslverr <= setup_ph && !(sel_exp || sel_npa);
      if (setup_ph && !pwrite && sel_exp) begin
        prdata <= {16'h0000, exp_view};
      end else if (setup_ph && !pwrite && sel_npa) begin
        prdata <= {16'h0000, npa_view};
      end else if (setup_ph) begin
        prdata <= anps_pkg::ZERO32; // Unmapped or write
      end
    end
  end

  // Checks. Captures, read answers and page-flag rules are held to the
  // stored register contents, so a wrong view or decode shows up here.

  // Toggle is stored inverted
  AST_TOGGLE_INV: assert property (@(posedge pclk) disable iff (!presetn)
    page_strobe |=> toggle_r == !$past(rx_toggle))
    else $error("toggle not inverted");

  // Code field taken with the strobe
  AST_CODE_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    page_strobe |=> code_r == $past(rx_code))
    else $error("code not captured");

  // Message page flag taken with the strobe
  AST_MSG_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    page_strobe |=> message_page_flag_r == $past(rx_message_page))
    else $error("message page flag wrong");

  // Comply flag taken with the strobe
  AST_COMPLY_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    page_strobe |=> partner_can_comply_r == $past(rx_partner_can_comply))
    else $error("comply flag wrong");

  // Reserved expansion bits read zero
  AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && sel_exp |-> prdata[31:5] == 27'h0000000)
    else $error("reserved bits not zero");

  // Local multi-page ability always reads one
  AST_LNP_ONE: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && sel_exp |-> prdata[anps_pkg::EXP_LNP_BIT])
    else $error("local next page bit not one");

  // Fault level follows the engine one cycle later
  AST_FAULT_TRACK: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 fault_r == $past(parallel_detect_fault))
    else $error("fault bit stale");

  // Partner multi-page level follows the engine
  AST_LPNP_TRACK: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 lpnp_r == $past(partner_multi_page_capable))
    else $error("partner next page bit stale");

  // Partner negotiation level follows the engine
  AST_LPAN_TRACK: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 lpan_r == $past(partner_negotiation_capable))
    else $error("partner autoneg bit stale");

  // An expansion read with no page arriving clears the flag
  AST_COR: assert property (@(posedge pclk) disable iff (!presetn)
    rd_exp && !page_strobe |=> !page_rx)
    else $error("page flag not cleared by read");

  // One access cycle per setup, then pready drops
  AST_PREADY: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph |=> pready ##1 !pready)
    else $error("pready timing wrong");

  // Page fields do not move between strobes
  AST_FIELDS_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !page_strobe |=> $stable(code_r) && $stable(message_page_flag_r)
      && $stable(partner_can_comply_r) && $stable(toggle_r))
    else $error("page fields moved without a page");

  // Every page sets the flag
  AST_PRX_SET: assert property (@(posedge pclk) disable iff (!presetn)
    page_strobe |=> page_rx)
    else $error("page flag not set");

  // Flag is sticky until an expansion read
  AST_PRX_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    page_rx && !rd_exp |=> page_rx)
    else $error("page flag dropped without a read");

  // Flag does not rise without a page
  AST_PRX_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    !page_rx && !page_strobe |=> !page_rx)
    else $error("page flag rose without a page");

  // Page on the clearing edge survives; answer shows the old flag
  AST_PRX_RACE: assert property (@(posedge pclk) disable iff (!presetn)
    rd_exp && page_strobe |=> page_rx
      && prdata[anps_pkg::EXP_PRX_BIT] == $past(page_rx))
    else $error("page lost on clearing read");

  // Expansion read reports the flag before the clear
  AST_PRX_READ: assert property (@(posedge pclk) disable iff (!presetn)
    rd_exp |=> prdata[anps_pkg::EXP_PRX_BIT] == $past(page_rx))
    else $error("page flag read wrong");

  // Expansion read reports the fault
  AST_EXP_FAULT_READ: assert property (@(posedge pclk) disable iff (!presetn)
    rd_exp |=> prdata[anps_pkg::EXP_FAULT_BIT] == $past(fault_r))
    else $error("fault bit read wrong");

  // Expansion read reports partner multi-page ability
  AST_EXP_LPNP_READ: assert property (@(posedge pclk) disable iff (!presetn)
    rd_exp |=> prdata[anps_pkg::EXP_LPNP_BIT] == $past(lpnp_r))
    else $error("partner next page bit read wrong");

  // Expansion read reports partner negotiation ability
  AST_EXP_LPAN_READ: assert property (@(posedge pclk) disable iff (!presetn)
    rd_exp |=> prdata[anps_pkg::EXP_LPAN_BIT] == $past(lpan_r))
    else $error("partner autoneg bit read wrong");

  // Next-page read reports the message page flag
  AST_NPA_MSG_READ: assert property (@(posedge pclk) disable iff (!presetn)
    rd_npa |=> prdata[anps_pkg::NPA_MSG_BIT] == $past(message_page_flag_r))
    else $error("message page bit read wrong");

  // Next-page read reports the comply flag
  AST_NPA_COMPLY_READ: assert property (@(posedge pclk) disable iff (!presetn)
    rd_npa |=> prdata[anps_pkg::NPA_COMPLY_BIT] == $past(partner_can_comply_r))
    else $error("comply bit read wrong");

  // Next-page read reports the inverted toggle
  AST_NPA_TOG_READ: assert property (@(posedge pclk) disable iff (!presetn)
    rd_npa |=> prdata[anps_pkg::NPA_TOG_BIT] == $past(toggle_r))
    else $error("toggle bit read wrong");

  // Next-page read reports the code field
  AST_NPA_CODE_READ: assert property (@(posedge pclk) disable iff (!presetn)
    rd_npa |=> prdata[CW-1:0] == $past(code_r))
    else $error("code field read wrong");

  // Next-page read leaves the unheld upper bits at zero
  AST_NPA_UPPER_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    rd_npa |=> prdata[31:14] == 18'h0_0000)
    else $error("next-page upper bits not zero");

  // A write answers with zero data and changes nothing
  AST_WR_NO_DATA: assert property (@(posedge pclk) disable iff (!presetn)
    wr_setup |=> prdata == anps_pkg::ZERO32)
    else $error("write returned data");

  // A write never clears the page flag
  AST_WR_NO_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    wr_setup && page_rx |=> page_rx)
    else $error("write cleared page flag");

  // Unmapped address answers with an error and zero data
  AST_ERR_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph && !(sel_exp || sel_npa) |=> pslverr && prdata == anps_pkg::ZERO32)
    else $error("unmapped address not refused");

  // Mapped address answers without an error
  AST_ERR_MAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph && (sel_exp || sel_npa) |=> !pslverr)
    else $error("mapped address refused");

  // Error only stands with the answer
  AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("slave error outside answer");

  // Read data holds between setups
  AST_PRDATA_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !setup_ph |=> $stable(prdata))
    else $error("read data moved without a setup");

  // Main scenarios: pages, clearing reads, the race, errors, view reads
  COV_PAGE: cover property (@(posedge pclk) disable iff (!presetn) page_strobe);
  COV_COR: cover property (@(posedge pclk) disable iff (!presetn) rd_exp && page_rx);
  COV_RACE: cover property (@(posedge pclk) disable iff (!presetn) rd_exp && page_strobe);
  COV_ERR: cover property (@(posedge pclk) disable iff (!presetn) pslverr && pready);
  COV_NPA: cover property (@(posedge pclk) disable iff (!presetn) rd_done && sel_npa);
endmodule : anps_status

// ### anps_status_tb.sv
/*
  Testbench for the partner page status block: APB reads and writes.
  Assumes the engine model drives the page side.
*/
`timescale 1ns/1ps
module anps_status_tb;
  logic        pclk    = 1'b0;  // 200 MHz
  logic        presetn = 1'b0;  // Active low
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err;
  logic        stb, msg, comply, tog, fault, lpnp, lpan;
  logic [10:0] code;
  int          n_fail  = 0;
  int          checked = 0;
  localparam logic [11:0] E = anps_pkg::EXP_ADDR;
  localparam logic [11:0] N = anps_pkg::NPA_ADDR;
  logic [31:0] lv_exp [3] = '{32'h0000_0005, 32'h0000_000C, 32'h0000_0014};
  always #2.5 pclk = ~pclk;
  anps_status dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .page_strobe(stb), .rx_message_page(msg),
    .rx_partner_can_comply(comply), .rx_toggle(tog), .rx_code(code),
    .parallel_detect_fault(fault), .partner_multi_page_capable(lpnp),
    .partner_negotiation_capable(lpan));
  anps_engine_model eng (.pclk(pclk), .page_strobe(stb), .rx_message_page(msg),
    .rx_partner_can_comply(comply), .rx_toggle(tog), .rx_code(code),
    .parallel_detect_fault(fault), .partner_multi_page_capable(lpnp),
    .partner_negotiation_capable(lpan));
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // One APB transfer; request held until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      $display("[FAIL] %0t no pready", $time);
      close_out();
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : xfer
  task automatic chk_d(input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t data %h expected %h", $time, g, e);
    end
  endtask : chk_d
  task automatic chk_e(input logic g, e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t slave error %b expected %b", $time, g, e);
    end
  endtask : chk_e
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk_e(err, 1'b0);
    chk_d(rd, e);
  endtask : rd_chk
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(E, 32'h0000_0004);
    rd_chk(N, 32'h0000_0000);
    $display("test reset values done");
    eng.send_page(1'b1, 1'b1, 1'b0, 11'h7FF);
    rd_chk(N, 32'h0000_3FFF);
    rd_chk(E, 32'h0000_0006);
    rd_chk(E, 32'h0000_0004);
    eng.send_page(1'b0, 1'b0, 1'b1, 11'h001);
    rd_chk(N, 32'h0000_0001);
    rd_chk(E, 32'h0000_0006);
    // Page lands on the clearing edge of a read
    fork
      eng.send_page(1'b1, 1'b0, 1'b1, 11'h555);
      rd_chk(E, 32'h0000_0004);
    join
    rd_chk(E, 32'h0000_0006);
    rd_chk(N, 32'h0000_2555);
    $display("test pages done");
    for (int i = 0; i < 3; i++) begin
      eng.set_levels(3'b001 << i);
      rd_chk(E, lv_exp[i]);
    end
    eng.set_levels(3'b111);
    xfer(1'b1, E, 32'hFFFF_FFFF);
    chk_e(err, 1'b0);
    rd_chk(E, 32'h0000_001D);
    xfer(1'b0, 12'h01C, 32'h0000_0000);
    chk_e(err, 1'b1);
    chk_d(rd, 32'h0000_0000);
    $display("test levels and writes done");
    close_out();
  end
endmodule : anps_status_tb
